/* File: src/lcf_fsm.sv */
// Link control layer 3 protocol entity state machine
// Functional notes
// - Three states; begin service enters in service, halt stops timer, returns out of service.
// - Exchange side behaves identically to access network side.
// - Event while awaiting acknowledgement is saved, replayed after returning in service.
// - Ack in service and timer expiry outside await are silently discarded.
// - Received link control answered with ack and forwarded upward unless out of service (then reported as error), no state change.
// - Ack while awaiting stops timer, returns to in service.
// - First expiry retransmits and restarts; second reports error, returns in service.
// - Supervision timer expires after one second, within ten percent.
module lcf_fsm
    import lcf_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = LCF_TIMEOUT_CYCLES,
    parameter int QUEUE_DEPTH    = LCF_QUEUE_DEPTH
) (
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    input  wire logic       I_BEGIN_SERVICE,
    input  wire logic       I_HALT_SERVICE,
    input  wire logic       I_FE_VALID,
    input  wire lcf_msg_s   I_FE,
    input  wire logic       I_RX_LC_VALID,
    input  wire lcf_msg_s   I_RX_LC,
    input  wire logic       I_RX_ACK_VALID,
    output logic            O_TX_LC_VALID,
    output lcf_msg_s        O_TX_LC,
    output logic            O_TX_ACK_VALID,
    output logic            O_FE_UP_VALID,
    output lcf_msg_s        O_FE_UP,
    output logic            O_ERR_REPORT,
    output lcf_state_e      O_STATE
);

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int CW = $clog2(QUEUE_DEPTH + 1);
    localparam logic [TW-1:0] TMR_LOAD = TW'(TIMEOUT_CYCLES);
    localparam logic [CW-1:0] Q_FULL   = CW'(QUEUE_DEPTH);

    lcf_state_e     state_reg;
    lcf_state_e     state_next;
    logic [TW-1:0]  tmr_cnt_reg;
    logic           second_reg;
    logic [PW-1:0]  wr_ptr_reg;
    logic [PW-1:0]  rd_ptr_reg;
    logic [CW-1:0]  count_reg;
    logic           wrote_reg;
    lcf_msg_s       head_data;

    logic in_oos;
    logic in_is;
    logic in_aw;
    logic halt;
    logic expiry;
    logic saved_ok;
    logic send_new;
    logic send_saved;
    logic push;
    logic pop;
    logic oos_err;
    logic full_err;

    // Same table on both sides of the interface, so one machine serves either
    assign in_oos   = (state_reg == LCF_OUT_OF_SERVICE);
    assign in_is    = (state_reg == LCF_IN_SERVICE);
    assign in_aw    = (state_reg == LCF_AWAIT_ACK);
    assign halt     = I_HALT_SERVICE && !in_oos;
    // Timer only counts in the await state, so a stray expiry cannot arise
    assign expiry   = in_aw && (tmr_cnt_reg == TW'(1));
    // Head word is stale for one cycle after a write into an empty queue
    assign saved_ok = (count_reg != '0) && !wrote_reg;
    assign send_saved = in_is && !halt && saved_ok;
    assign send_new   = in_is && !halt && (count_reg == '0) && I_FE_VALID;
    // Saved events keep arrival order: new one queued behind the head
    assign push     = !halt && I_FE_VALID && (count_reg != Q_FULL) &&
                      (in_aw || (in_is && count_reg != '0));
    assign pop      = send_saved;
    assign oos_err  = in_oos && (I_RX_LC_VALID || I_RX_ACK_VALID || I_FE_VALID);
    // Overflowing the saved-event store is reported rather than lost silently
    assign full_err = !halt && I_FE_VALID && (count_reg == Q_FULL) && (in_aw || (in_is && count_reg != '0));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LCF_OUT_OF_SERVICE: begin
                if (I_BEGIN_SERVICE) begin
                    state_next = LCF_IN_SERVICE;
                end
            end
            LCF_IN_SERVICE: begin
                if (halt) begin
                    state_next = LCF_OUT_OF_SERVICE;
                end else if (send_saved || send_new) begin
                    state_next = LCF_AWAIT_ACK;
                end
            end
            LCF_AWAIT_ACK: begin
                if (halt) begin
                    state_next = LCF_OUT_OF_SERVICE;
                end else if (I_RX_ACK_VALID) begin
                    state_next = LCF_IN_SERVICE;
                end else if (expiry && second_reg) begin
                    state_next = LCF_IN_SERVICE;
                end
            end
            default: begin
                state_next = LCF_OUT_OF_SERVICE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_reg <= LCF_OUT_OF_SERVICE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Supervision timer and its retry flag
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            tmr_cnt_reg <= '0;
            second_reg  <= 1'b0;
        end else if (halt || (in_aw && I_RX_ACK_VALID) || (expiry && second_reg)) begin
            tmr_cnt_reg <= '0;
            second_reg  <= 1'b0;
        end else if (send_saved || send_new) begin
            tmr_cnt_reg <= TMR_LOAD;
            second_reg  <= 1'b0;
        end else if (expiry) begin
            tmr_cnt_reg <= TMR_LOAD;
            second_reg  <= 1'b1;
        end else if (in_aw) begin
            tmr_cnt_reg <= tmr_cnt_reg - TW'(1);
        end
    end

    // Saved-event queue pointers; stopping traffic discards pending events
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            wrote_reg  <= 1'b0;
        end else if (halt) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            wrote_reg  <= 1'b0;
        end else begin
            wrote_reg <= push && (count_reg == '0);
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(QUEUE_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(QUEUE_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
            end
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

    lcf_mem #(
        .W     ($bits(lcf_msg_s)),
        .DEPTH (QUEUE_DEPTH),
        .AW    (PW)
    ) u_saved (
        .i_clk     (I_CLOCK),
        .i_wr_en   (push),
        .i_wr_addr (wr_ptr_reg),
        .i_wr_data (I_FE),
        .i_rd_addr (rd_ptr_reg),
        .o_rd_data (head_data)
    );

    // Outgoing link control, held for a retransmission
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_TX_LC_VALID <= 1'b0;
            O_TX_LC       <= '0;
        end else begin
            O_TX_LC_VALID <= send_saved || send_new || (expiry && !second_reg && !halt && !I_RX_ACK_VALID);
            if (send_saved) begin
                O_TX_LC <= head_data;
            end else if (send_new) begin
                O_TX_LC <= I_FE;
            end
        end
    end

    // Peer link control: acknowledge and forward upward
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_TX_ACK_VALID <= 1'b0;
            O_FE_UP_VALID  <= 1'b0;
            O_FE_UP        <= '0;
        end else begin
            O_TX_ACK_VALID <= I_RX_LC_VALID && !in_oos;
            O_FE_UP_VALID  <= I_RX_LC_VALID && !in_oos;
            if (I_RX_LC_VALID && !in_oos) begin
                O_FE_UP <= I_RX_LC;
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_ERR_REPORT <= 1'b0;
            O_STATE      <= LCF_OUT_OF_SERVICE;
        end else begin
            O_ERR_REPORT <= oos_err || full_err || (expiry && second_reg && !halt && !I_RX_ACK_VALID);
            O_STATE      <= state_next;
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    property p_begin;
        in_oos && I_BEGIN_SERVICE |=> in_is ##0 O_STATE == LCF_IN_SERVICE;
    endproperty
    a_begin: assert property (p_begin) else $error("begin service did not enter in service");

    property p_halt;
        halt |=> in_oos && tmr_cnt_reg == '0 && count_reg == '0;
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop timer and leave service");

    property p_send;
        in_is && !I_HALT_SERVICE && I_FE_VALID && count_reg == '0
            |=> O_TX_LC_VALID && O_TX_LC == $past(I_FE) && in_aw && tmr_cnt_reg == TMR_LOAD;
    endproperty
    a_send: assert property (p_send) else $error("event in service not sent with timer start");

    property p_save;
        in_aw && I_FE_VALID && !I_HALT_SERVICE && count_reg != Q_FULL
            |=> count_reg == $past(count_reg) + CW'(1) && O_TX_LC == $past(O_TX_LC)
                && (!O_TX_LC_VALID || $past(expiry));
    endproperty
    a_save: assert property (p_save) else $error("event while awaiting not saved");

    property p_replay;
        in_is && saved_ok && !I_HALT_SERVICE |=> O_TX_LC_VALID && O_TX_LC == $past(head_data) && in_aw;
    endproperty
    a_replay: assert property (p_replay) else $error("saved event not replayed");

    property p_unexpected;
        in_is && I_RX_ACK_VALID && !I_HALT_SERVICE && !I_FE_VALID && count_reg == '0
            |=> in_is && !O_ERR_REPORT && !O_TX_LC_VALID;
    endproperty
    a_unexpected: assert property (p_unexpected) else $error("ack in service not discarded");

    property p_oos_err;
        in_oos && (I_RX_LC_VALID || I_RX_ACK_VALID || I_FE_VALID) && !I_BEGIN_SERVICE
            |=> O_ERR_REPORT && in_oos && !O_TX_ACK_VALID;
    endproperty
    a_oos_err: assert property (p_oos_err) else $error("out of service input gave no error");

    property p_answer;
        !in_oos && I_RX_LC_VALID |=> O_TX_ACK_VALID && O_FE_UP_VALID && O_FE_UP == $past(I_RX_LC);
    endproperty
    a_answer: assert property (p_answer) else $error("link control not answered and forwarded");

    property p_ack;
        in_aw && I_RX_ACK_VALID && !I_HALT_SERVICE |=> in_is && tmr_cnt_reg == '0;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not end the wait");

    property p_retry;
        expiry && !second_reg && !I_HALT_SERVICE && !I_RX_ACK_VALID
            |=> O_TX_LC_VALID && O_TX_LC == $past(O_TX_LC) && second_reg && tmr_cnt_reg == TMR_LOAD;
    endproperty
    a_retry: assert property (p_retry) else $error("first expiry did not retransmit");

    property p_give_up;
        expiry && second_reg && !I_HALT_SERVICE && !I_RX_ACK_VALID |=> O_ERR_REPORT && in_is;
    endproperty
    a_give_up: assert property (p_give_up) else $error("second expiry not reported");

    property p_count;
        in_aw && tmr_cnt_reg > TW'(1) && !I_HALT_SERVICE && !I_RX_ACK_VALID
            |=> tmr_cnt_reg == $past(tmr_cnt_reg) - TW'(1);
    endproperty
    a_count: assert property (p_count) else $error("supervision timer not counting");

    c_handshake: cover property (send_new ##[1:20] (in_aw && I_RX_ACK_VALID));
    c_saved:     cover property (in_aw && push ##[1:20] send_saved);
    c_give_up:   cover property (expiry && second_reg);
    c_peer:      cover property (in_aw && I_RX_LC_VALID);

endmodule : lcf_fsm

/* File: src/lcf_pkg.sv */
// Shared constants and types for the link control protocol entity
package lcf_pkg;

    localparam int LCF_FUNC_W        = 8;
    localparam int LCF_ADDR_W        = 8;
    localparam int LCF_QUEUE_DEPTH   = 4;
    // Nominal timeout; the allowed window is plus or minus ten percent
    localparam int LCF_TIMEOUT_NS    = 1_000_000_000;
    localparam int LCF_CLK_PERIOD_NS = 10;
    localparam int LCF_TIMEOUT_CYCLES = LCF_TIMEOUT_NS / LCF_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LCF_OUT_OF_SERVICE,
        LCF_IN_SERVICE,
        LCF_AWAIT_ACK
    } lcf_state_e;

    typedef struct packed {
        logic [LCF_FUNC_W-1:0] func;
        logic [LCF_ADDR_W-1:0] addr;
    } lcf_msg_s;

endpackage : lcf_pkg

/* File: src/lcf_mem.sv */
// Small storage for saved link function events, registered read port
module lcf_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [W-1:0]  i_wr_data,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [W-1:0]  o_rd_data
);

    logic [W-1:0] mem_reg [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    // Read before write: a word written this cycle shows one cycle later
    always_ff @(posedge i_clk) begin
        o_rd_data <= mem_reg[i_rd_addr];
    end

endmodule : lcf_mem

/* File: verification/lcf_peer_model.sv */
// Peer link control entity that acknowledges the latest LINK CONTROL it receives, after a nonzero delay
module lcf_peer_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_tx_lc_valid,
    input  wire logic [7:0] i_ack_delay,
    output logic            o_rx_ack_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] wait_reg;

    // Zero delay gives a silent peer, so the timer path can run out
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_reg       <= 8'h00;
            o_rx_ack_valid <= 1'b0;
        end else begin
            o_rx_ack_valid <= 1'b0;
            if (i_tx_lc_valid && i_ack_delay != 8'h00) begin
                wait_reg <= i_ack_delay;
            end else if (wait_reg != 8'h00) begin
                wait_reg       <= wait_reg - 8'h01;
                o_rx_ack_valid <= (wait_reg == 8'h01);
            end
        end
    end
endmodule : lcf_peer_model

/* File: verification/tb_link_control_l3_fsm.sv */
// Self-checking testbench for the link control protocol entity
module tb_link_control_l3_fsm
    import lcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMO = 20;

    logic       clk, rst, begin_c, halt_c, fe_v, lc_v, tb_ack, peer_ack;
    logic       tx_v, txack_v, up_v, err;
    lcf_msg_s   fe_d, lc_d, tx_d, up_d;
    lcf_state_e st;
    logic [7:0] dly;
    int         failures, tests_run;

    lcf_fsm #(.TIMEOUT_CYCLES(TMO), .QUEUE_DEPTH(4)) lcf_fsm_inst (
        .I_CLOCK(clk), .I_RST(rst), .I_BEGIN_SERVICE(begin_c), .I_HALT_SERVICE(halt_c),
        .I_FE_VALID(fe_v), .I_FE(fe_d), .I_RX_LC_VALID(lc_v), .I_RX_LC(lc_d),
        .I_RX_ACK_VALID(tb_ack | peer_ack), .O_TX_LC_VALID(tx_v), .O_TX_LC(tx_d),
        .O_TX_ACK_VALID(txack_v), .O_FE_UP_VALID(up_v), .O_FE_UP(up_d),
        .O_ERR_REPORT(err), .O_STATE(st));

    lcf_peer_model lcf_peer_model_inst (
        .i_clk(clk), .i_rst(rst), .i_tx_lc_valid(tx_v), .i_ack_delay(dly),
        .o_rx_ack_valid(peer_ack));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Kind 0 begin, 1 halt, 2 event, 3 peer LINK CONTROL, other ack
    task automatic fire(input int k, input logic [15:0] d);
        @(posedge clk);
        fe_d <= lcf_msg_s'(d);
        lc_d <= lcf_msg_s'(d);
        case (k)
            0: begin_c <= 1'b1;
            1: halt_c <= 1'b1;
            2: fe_v <= 1'b1;
            3: lc_v <= 1'b1;
            default: tb_ack <= 1'b1;
        endcase
        @(posedge clk);
        {begin_c, halt_c, fe_v, lc_v, tb_ack} <= 5'h00;
        #1;
    endtask : fire

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_st(input lcf_state_e got, input lcf_state_e exp);
        chk_val(16'(got), 16'(exp));
    endtask : chk_st

    // Neither a send nor an error report may appear for n cycles
    task automatic quiet(input int n);
        repeat (n) begin
            step(1);
            chk_val(16'({tx_v, err}), 16'h0000);
        end
    endtask : quiet

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic t_out_of_service();
        for (int k = 2; k < 5; k++) begin
            fire(k, 16'h1234);
            chk_val(16'({err, txack_v}), 16'h0002);
            chk_st(st, LCF_OUT_OF_SERVICE);
        end
        fire(1, 16'h0000);
        chk_val(16'(err), 16'h0000);
        $display("test out_of_service done");
    endtask : t_out_of_service

    task automatic t_send_and_save();
        int n;
        dly = 8'h01;
        fire(0, 16'h0000);
        chk_st(st, LCF_IN_SERVICE);
        fire(4, 16'h0000);
        chk_val(16'(err), 16'h0000);
        chk_st(st, LCF_IN_SERVICE);
        fire(2, 16'hA15A);
        chk_val(16'(tx_v), 16'h0001);
        chk_val(tx_d, 16'hA15A);
        chk_st(st, LCF_AWAIT_ACK);
        fire(2, 16'hB26B);
        chk_val(16'(tx_v), 16'h0000);
        for (n = 0; n < 40 && tx_v !== 1'b1; n++) step(1);
        chk_val(16'(tx_v), 16'h0001);
        if (tx_v !== 1'b1) tally_and_finish();
        chk_val(tx_d, 16'hB26B);
        step(4);
        chk_st(st, LCF_IN_SERVICE);
        $display("test send_and_save done");
    endtask : t_send_and_save

    task automatic t_peer_and_halt();
        dly = 8'h00;
        fire(3, 16'hC37C);
        chk_val(16'({txack_v, up_v}), 16'h0003);
        chk_val(up_d, 16'hC37C);
        chk_st(st, LCF_IN_SERVICE);
        fire(2, 16'hD48D);
        fire(3, 16'hE59E);
        chk_val(16'({txack_v, up_v}), 16'h0003);
        chk_val(up_d, 16'hE59E);
        chk_st(st, LCF_AWAIT_ACK);
        fire(1, 16'h0000);
        chk_st(st, LCF_OUT_OF_SERVICE);
        quiet(2 * TMO + 2);
        $display("test peer_and_halt done");
    endtask : t_peer_and_halt

    task automatic t_timeout();
        dly = 8'h00;
        fire(0, 16'h0000);
        fire(2, 16'hF66F);
        quiet(TMO - 1);
        step(1);
        chk_val(16'(tx_v), 16'h0001);
        chk_val(tx_d, 16'hF66F);
        chk_st(st, LCF_AWAIT_ACK);
        quiet(TMO - 1);
        step(1);
        chk_val(16'(err), 16'h0001);
        chk_st(st, LCF_IN_SERVICE);
        $display("test timeout done");
    endtask : t_timeout

    initial begin
        failures = 0;
        tests_run = 0;
        rst = 1'b1;
        {begin_c, halt_c, fe_v, lc_v, tb_ack} = 5'h00;
        fe_d = 16'h0000;
        lc_d = 16'h0000;
        dly = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        step(1);
        chk_st(st, LCF_OUT_OF_SERVICE);
        chk_val(16'({tx_v, txack_v, up_v, err}), 16'h0000);
        t_out_of_service();
        t_send_and_save();
        t_peer_and_halt();
        t_timeout();
        tally_and_finish();
    end
endmodule : tb_link_control_l3_fsm
